// ### shared/async_wait_pkg.sv
// Constants shared by the asynchronous wait and interrupt register block
package async_wait_pkg;

    // ------------------------------------------------------------------
    // Register bus geometry
    // ------------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;

    // ------------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] OFS_WAIT_CONFIG  = 8'h00;
    localparam logic [7:0] OFS_RAW_STATUS   = 8'h04;
    localparam logic [7:0] OFS_EN_STATUS    = 8'h08;
    localparam logic [7:0] OFS_ENABLE_SET   = 8'h0C;
    localparam logic [7:0] OFS_ENABLE_CLEAR = 8'h10;

    // ------------------------------------------------------------------
    // Field positions of async_wait_config
    // ------------------------------------------------------------------
    localparam int READY_POL_BIT = 30;
    localparam int TA_LSB        = 8;
    localparam int TA_W          = 3;
    localparam int MAXW_LSB      = 0;
    localparam int MAXW_W        = 8;

    // ------------------------------------------------------------------
    // Interrupt bit positions (raw, enabled, enable views alike)
    // ------------------------------------------------------------------
    localparam int TIMEOUT_BIT = 0;
    localparam int ILLEGAL_BIT = 2;
    localparam int IRQ_W       = 3;

    // ------------------------------------------------------------------
    // Reset values and timing counts
    // ------------------------------------------------------------------
    localparam logic [31:0] WAIT_CONFIG_RST = 32'h4000_0000;
    localparam logic [31:0] WAIT_CONFIG_MSK = 32'h4000_07FF;
    localparam logic [2:0]  IRQ_RST         = 3'h0;
    localparam int          WAIT_UNIT       = 16;
    localparam int          WAIT_CNT_W      = 12;
    localparam int          GAP_CNT_W       = 4;

    typedef enum logic [1:0] {
        WAIT_IDLE    = 2'b00,
        WAIT_EXTEND  = 2'b01,
        WAIT_EXPIRED = 2'b10
    } wait_state_t;

endpackage : async_wait_pkg

// ### rtl/async_wait_timeout_irq_regs.sv
// Asynchronous wait configuration, timeout and interrupt status registers
`timescale 1ns/1ps
// ----------------------------------------------------------------------
// Operation
// ----------------------------------------------------------------------
// Operation
// - Ready pin active high when polarity bit is 1, low when 0.
// - Gap between asynchronous accesses is turnaround field plus one.
// - Extended cycle waits at most max wait times 16 cycles, one cycle when max wait is 0.
// - Raw timeout bit sets on timeout regardless of interrupt enable.
// - Writing 1 to raw timeout bit clears raw and enabled timeout.
// - Raw illegal-access bit sets on any illegal access.
// - Writing 1 to raw illegal bit clears raw and enabled illegal.
// - Raw status shows events whether or not interrupts are enabled.
// - Enabled illegal bit sets only while illegal enable is 1.
// - Writing 1 to enabled illegal bit clears it and raw bit.
// - Enabled timeout bit sets only while timeout enable is 1.
// - Writing 1 to enabled timeout bit clears it and raw bit.
// - Writing 1 to enable-set bit enables; both views read 1.
// - Writing 1 to enable-clear bit disables; both views read 0.
module async_wait_timeout_irq_regs (
    input  wire logic                               sys_clk,
    input  wire logic                               rst,
    input  wire logic [async_wait_pkg::ADDR_W-1:0]  regAddr,
    input  wire logic [async_wait_pkg::DATA_W-1:0]  regWrData,
    input  wire logic                               regWrite,
    input  wire logic                               regRead,
    output logic      [async_wait_pkg::DATA_W-1:0]  regRdData,
    input  wire logic                               asyncReadyPin,
    input  wire logic                               accessStart,
    input  wire logic                               strobeActive,
    input  wire logic                               accessEnd,
    input  wire logic                               illegalAccess,
    output logic                                    strobeExtend,
    output logic                                    waitTimeout,
    output logic                                    accessAllowed,
    output logic                                    irq
);
    import async_wait_pkg::*;

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    logic [31:0]           waitConfig_reg;
    logic [IRQ_W-1:0]      rawStatus_reg;
    logic [IRQ_W-1:0]      rawStatus_next;
    logic [IRQ_W-1:0]      enStatus_reg;
    logic [IRQ_W-1:0]      enStatus_next;
    logic [IRQ_W-1:0]      irqEnable_reg;
    logic [IRQ_W-1:0]      irqEnable_next;
    logic [DATA_W-1:0]     rdData_reg;
    logic [WAIT_CNT_W-1:0] waitCount_reg;
    logic [WAIT_CNT_W-1:0] waitCount_next;
    logic [GAP_CNT_W-1:0]  gapCount_reg;
    logic [GAP_CNT_W-1:0]  gapCount_next;
    wait_state_t           waitState_reg;
    wait_state_t           waitState_next;
    logic                  timeoutPulse_reg;

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic logic hitWrite(input logic [7:0] a,
                                      input logic [7:0] ofs,
                                      input logic       wr);
        hitWrite = wr && (a == ofs);
    endfunction : hitWrite

    function automatic logic [DATA_W-1:0] padIrq(input logic [2:0] v);
        padIrq = {{(DATA_W-IRQ_W){1'b0}}, v};
    endfunction : padIrq

    // ------------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------------
    wire logic wrConfig   = hitWrite(regAddr, OFS_WAIT_CONFIG, regWrite);
    wire logic wrRaw      = hitWrite(regAddr, OFS_RAW_STATUS, regWrite);
    wire logic wrEnStat   = hitWrite(regAddr, OFS_EN_STATUS, regWrite);
    wire logic wrEnSet    = hitWrite(regAddr, OFS_ENABLE_SET, regWrite);
    wire logic wrEnClear  = hitWrite(regAddr, OFS_ENABLE_CLEAR, regWrite);

    wire logic [IRQ_W-1:0] wrBits    = regWrData[IRQ_W-1:0];
    wire logic [IRQ_W-1:0] statusClr = ({IRQ_W{wrRaw}} & wrBits)
                                     | ({IRQ_W{wrEnStat}} & wrBits);

    // ------------------------------------------------------------------
    // Configuration fields
    // ------------------------------------------------------------------
    wire logic            readyPolHigh = waitConfig_reg[READY_POL_BIT];
    wire logic [TA_W-1:0] taField = waitConfig_reg[TA_LSB +: TA_W];
    wire logic [MAXW_W-1:0] maxWait = waitConfig_reg[MAXW_LSB +: MAXW_W];
    // Limit in cycles; 255 * 16 still fits the 12-bit counter
    wire logic [WAIT_CNT_W-1:0] waitLimit =
        WAIT_CNT_W'({maxWait, 4'h0});

    // ------------------------------------------------------------------
    // Ready pin and timeout
    // ------------------------------------------------------------------
    // Polarity is applied before any use of the pin
    wire logic readyActive = (asyncReadyPin == readyPolHigh);
    wire logic wantExtend  = strobeActive && readyActive;
    wire logic limitHit    = (waitCount_reg >= waitLimit);

    always_comb begin
        waitState_next = waitState_reg;
        waitCount_next = waitCount_reg;
        case (waitState_reg)
            WAIT_IDLE: begin
                if (wantExtend && !accessStart) begin
                    waitState_next = WAIT_EXTEND;
                    waitCount_next = WAIT_CNT_W'(1);
                end
            end
            WAIT_EXTEND: begin
                if (!wantExtend) begin
                    waitState_next = WAIT_IDLE;
                end else if (limitHit) begin
                    waitState_next = WAIT_EXPIRED;
                end else begin
                    waitCount_next = waitCount_reg + WAIT_CNT_W'(1);
                end
            end
            WAIT_EXPIRED: begin
                if (!strobeActive) begin
                    waitState_next = WAIT_IDLE;
                end
            end
            default: begin
                waitState_next = WAIT_IDLE;
            end
        endcase
        if (accessStart) begin
            waitState_next = WAIT_IDLE;
            waitCount_next = '0;
        end
    end

    // Zero limit ends the cycle on its first extended beat
    wire logic timeoutEvent = (waitState_reg == WAIT_EXTEND)
                            && wantExtend && limitHit && !accessStart;

    // Once expired the strobe is released even if the pin stays active
    assign strobeExtend = wantExtend
                        && (waitState_reg != WAIT_EXPIRED)
                        && !timeoutEvent;
    assign waitTimeout  = timeoutPulse_reg;

    // ------------------------------------------------------------------
    // Turnaround gap
    // ------------------------------------------------------------------
    always_comb begin
        gapCount_next = gapCount_reg;
        if (accessEnd) begin
            gapCount_next = GAP_CNT_W'(taField) + GAP_CNT_W'(1);
        end else if (gapCount_reg != '0) begin
            gapCount_next = gapCount_reg - GAP_CNT_W'(1);
        end
    end

    assign accessAllowed = (gapCount_reg == '0);

    // ------------------------------------------------------------------
    // Interrupt status and enables
    // ------------------------------------------------------------------
    wire logic [IRQ_W-1:0] eventBits = {illegalAccess, 1'b0, timeoutEvent};

    // A new event wins over a clear in the same cycle
    assign rawStatus_next = eventBits
                          | (rawStatus_reg & ~statusClr);
    assign enStatus_next  = (eventBits & irqEnable_reg)
                          | (enStatus_reg & ~statusClr);
    // Set beats clear when both land on one bit in a single write
    assign irqEnable_next = ({IRQ_W{wrEnSet}} & wrBits)
                          | (irqEnable_reg
                             & ~({IRQ_W{wrEnClear}} & wrBits));

    assign irq = |enStatus_reg;

    // ------------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------------
    wire logic [DATA_W-1:0] rdMux =
        (regAddr == OFS_WAIT_CONFIG)  ? waitConfig_reg :
        (regAddr == OFS_RAW_STATUS)   ? padIrq(rawStatus_reg) :
        (regAddr == OFS_EN_STATUS)    ? padIrq(enStatus_reg) :
        (regAddr == OFS_ENABLE_SET)   ? padIrq(irqEnable_reg) :
        (regAddr == OFS_ENABLE_CLEAR) ? padIrq(irqEnable_reg) :
        '0;

    assign regRdData = rdData_reg;

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            waitConfig_reg <= WAIT_CONFIG_RST;
        end else if (wrConfig) begin
            waitConfig_reg <= regWrData & WAIT_CONFIG_MSK;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            rawStatus_reg <= IRQ_RST;
            enStatus_reg  <= IRQ_RST;
            irqEnable_reg <= IRQ_RST;
        end else begin
            rawStatus_reg <= rawStatus_next;
            enStatus_reg  <= enStatus_next;
            irqEnable_reg <= irqEnable_next;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            waitState_reg    <= WAIT_IDLE;
            waitCount_reg    <= '0;
            gapCount_reg     <= '0;
            timeoutPulse_reg <= 1'b0;
            rdData_reg       <= '0;
        end else begin
            waitState_reg    <= waitState_next;
            waitCount_reg    <= waitCount_next;
            gapCount_reg     <= gapCount_next;
            timeoutPulse_reg <= timeoutEvent;
            rdData_reg       <= regRead ? rdMux : '0;
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    sequence clrTimeoutRaw;
        wrRaw && regWrData[TIMEOUT_BIT] && !timeoutEvent;
    endsequence

    sequence clrTimeoutEn;
        wrEnStat && regWrData[TIMEOUT_BIT] && !timeoutEvent;
    endsequence

    sequence clrIllegalAny;
        (wrRaw || wrEnStat) && regWrData[ILLEGAL_BIT] && !illegalAccess;
    endsequence

    sequence clrIllegalEn;
        wrEnStat && regWrData[ILLEGAL_BIT] && !illegalAccess;
    endsequence

    a_ready_polarity: assert property (
        @(posedge sys_clk) disable iff (rst)
        (strobeActive && waitState_reg == WAIT_IDLE && !accessStart)
            |-> (strobeExtend == (asyncReadyPin == readyPolHigh)))
        else $error("strobe extension ignores ready polarity");

    a_turnaround_gap: assert property (
        @(posedge sys_clk) disable iff (rst)
        (accessEnd && taField == 3'h3) |=> !accessAllowed [*4]
            ##1 accessAllowed)
        else $error("turnaround gap length wrong");

    a_wait_limit: assert property (
        @(posedge sys_clk) disable iff (rst)
        (waitState_reg == WAIT_EXTEND && waitCount_reg > waitLimit)
            |-> 1'b0)
        else $error("wait count ran past its limit");

    a_timeout_raw: assert property (
        @(posedge sys_clk) disable iff (rst)
        timeoutEvent |=> rawStatus_reg[TIMEOUT_BIT] && waitTimeout)
        else $error("timeout did not set raw status");

    a_clear_timeout_raw: assert property (
        @(posedge sys_clk) disable iff (rst)
        clrTimeoutRaw |=> !rawStatus_reg[TIMEOUT_BIT]
            && !enStatus_reg[TIMEOUT_BIT])
        else $error("raw timeout clear failed");

    a_illegal_raw: assert property (
        @(posedge sys_clk) disable iff (rst)
        illegalAccess |=> rawStatus_reg[ILLEGAL_BIT])
        else $error("illegal access not recorded");

    a_clear_illegal: assert property (
        @(posedge sys_clk) disable iff (rst)
        clrIllegalAny |=> !rawStatus_reg[ILLEGAL_BIT]
            && !enStatus_reg[ILLEGAL_BIT])
        else $error("illegal clear failed");

    a_clear_illegal_en: assert property (
        @(posedge sys_clk) disable iff (rst)
        clrIllegalEn |=> !enStatus_reg[ILLEGAL_BIT]
            && !rawStatus_reg[ILLEGAL_BIT])
        else $error("enabled illegal clear missed raw bit");

    a_raw_read_view: assert property (
        @(posedge sys_clk) disable iff (rst)
        (regRead && regAddr == OFS_RAW_STATUS)
            |=> regRdData[IRQ_W-1:0] == $past(rawStatus_reg))
        else $error("raw status read mismatch");

    a_illegal_gated: assert property (
        @(posedge sys_clk) disable iff (rst)
        (illegalAccess && !enStatus_reg[ILLEGAL_BIT])
            |=> enStatus_reg[ILLEGAL_BIT] == $past(irqEnable_reg[ILLEGAL_BIT]))
        else $error("enabled illegal bit ignores enable");

    a_timeout_gated: assert property (
        @(posedge sys_clk) disable iff (rst)
        (timeoutEvent && !irqEnable_reg[TIMEOUT_BIT]
            && !enStatus_reg[TIMEOUT_BIT])
            |=> !enStatus_reg[TIMEOUT_BIT])
        else $error("disabled timeout reached enabled status");

    a_timeout_enabled: assert property (
        @(posedge sys_clk) disable iff (rst)
        (timeoutEvent && irqEnable_reg[TIMEOUT_BIT])
            |=> enStatus_reg[TIMEOUT_BIT])
        else $error("enabled timeout bit not set");

    a_clear_timeout_en: assert property (
        @(posedge sys_clk) disable iff (rst)
        clrTimeoutEn |=> !rawStatus_reg[TIMEOUT_BIT])
        else $error("enabled timeout clear missed raw bit");

    a_enable_set: assert property (
        @(posedge sys_clk) disable iff (rst)
        (wrEnSet && regWrData[ILLEGAL_BIT]) |=> irqEnable_reg[ILLEGAL_BIT])
        else $error("enable set failed");

    a_enable_clear: assert property (
        @(posedge sys_clk) disable iff (rst)
        (wrEnClear && regWrData[TIMEOUT_BIT] && !wrEnSet)
            |=> !irqEnable_reg[TIMEOUT_BIT])
        else $error("enable clear failed");

    a_irq_level: assert property (
        @(posedge sys_clk) disable iff (rst)
        irq == (enStatus_reg[TIMEOUT_BIT] || enStatus_reg[ILLEGAL_BIT]))
        else $error("interrupt output mismatch");

    a_counter_restart: assert property (
        @(posedge sys_clk) disable iff (rst)
        accessStart |=> waitCount_reg == '0
            && waitState_reg == WAIT_IDLE)
        else $error("wait counter not reset at access start");

endmodule : async_wait_timeout_irq_regs

// ### dv/ready_pin_model.sv
// External asynchronous device that holds the ready pin during strobes
`timescale 1ns/1ps
module ready_pin_model (
    input  wire logic       sys_clk,
    input  wire logic       strobeActive,
    input  wire logic       activeHigh,
    input  wire logic [7:0] holdCycles,
    output logic            asyncReadyPin
);
    logic [7:0] heldCnt_reg;

    // ------------------------------------------------------------------
    // Strobe cycle count
    // ------------------------------------------------------------------
    // Saturates at 255 so a released pin is never re-asserted later in a long strobe
    always_ff @(posedge sys_clk) begin
        if (!strobeActive) begin
            heldCnt_reg <= 8'h00;
        end else if (heldCnt_reg != 8'hFF) begin
            heldCnt_reg <= heldCnt_reg + 8'h01;
        end
    end

    // Outside a strobe the pin rests at its inactive level
    assign asyncReadyPin = (strobeActive && heldCnt_reg < holdCycles)
                           ? activeHigh : ~activeHigh;
endmodule : ready_pin_model

// ### dv/test_async_wait_timeout_irq_regs.sv
// Self-checking bench for the wait, timeout and interrupt registers
`timescale 1ns/1ps
module test_async_wait_timeout_irq_regs;
    import async_wait_pkg::*;
    typedef struct {logic wr; logic [7:0] a; logic [31:0] d;} row_t;
    logic        sys_clk = 1'b0;
    logic        rst = 1'b1;
    logic [7:0]  regAddr = 8'h00;
    logic [31:0] regWrData = 32'h0000_0000;
    logic        regWrite = 1'b0;
    logic        regRead = 1'b0;
    logic [31:0] regRdData;
    logic        asyncReadyPin;
    logic        accessStart = 1'b0;
    logic        strobeActive = 1'b0;
    logic        accessEnd = 1'b0;
    logic        illegalAccess = 1'b0;
    logic        strobeExtend;
    logic        waitTimeout;
    logic        accessAllowed;
    logic        irq;
    logic        activeHigh = 1'b1;
    logic [7:0]  holdCycles = 8'h00;
    int          miscompares = 0;
    int          totalChecks = 0;
    row_t        tbl[$];

    always #2 sys_clk = ~sys_clk;

    async_wait_timeout_irq_regs async_wait_timeout_irq_regs_inst (
        .sys_clk(sys_clk), .rst(rst), .regAddr(regAddr),
        .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead),
        .regRdData(regRdData), .asyncReadyPin(asyncReadyPin),
        .accessStart(accessStart), .strobeActive(strobeActive),
        .accessEnd(accessEnd), .illegalAccess(illegalAccess),
        .strobeExtend(strobeExtend), .waitTimeout(waitTimeout),
        .accessAllowed(accessAllowed), .irq(irq));

    ready_pin_model ready_pin_model_inst (
        .sys_clk(sys_clk), .strobeActive(strobeActive),
        .activeHigh(activeHigh), .holdCycles(holdCycles),
        .asyncReadyPin(asyncReadyPin));

    // ------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------
    task automatic check(input string what, input logic [31:0] exp,
                         input logic [31:0] got);
        totalChecks++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        regWrite <= 1'b1;
        regAddr <= a;
        regWrData <= d;
        @(posedge sys_clk);
        regWrite <= 1'b0;
        #1;
    endtask : wr

    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        @(posedge sys_clk);
        regRead <= 1'b1;
        regAddr <= a;
        @(posedge sys_clk);
        regRead <= 1'b0;
        #1;
        check($sformatf("read %h", a), exp, regRdData);
    endtask : rdchk

    task automatic illegal_pulse();
        @(posedge sys_clk);
        illegalAccess <= 1'b1;
        @(posedge sys_clk);
        illegalAccess <= 1'b0;
        #1;
    endtask : illegal_pulse

    // One access: extension cycles, timeout pulse cycle, then the gap
    task automatic access(input logic [7:0] hold, input int expExt,
                          input int expTo, input int expGap);
        int ext;
        int toAt;
        int gap;
        ext = 0;
        toAt = -1;
        gap = 0;
        holdCycles <= hold;
        @(posedge sys_clk);
        accessStart <= 1'b1;
        @(posedge sys_clk);
        accessStart <= 1'b0;
        strobeActive <= 1'b1;
        for (int i = 0; i < 40; i++) begin
            #1;
            if (strobeExtend === 1'b1) ext++;
            if (waitTimeout === 1'b1) toAt = i;
            @(posedge sys_clk);
        end
        strobeActive <= 1'b0;
        accessEnd <= 1'b1;
        @(posedge sys_clk);
        accessEnd <= 1'b0;
        repeat (20) begin
            #1;
            if (accessAllowed !== 1'b1) gap++;
            @(posedge sys_clk);
        end
        check("extend cycles", expExt, ext);
        check("timeout cycle", expTo, toAt);
        check("gap cycles", expGap, gap);
    endtask : access

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", totalChecks, miscompares);
        if (miscompares == 0 && totalChecks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : tally_and_finish

    // ------------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------------
    initial begin
        tbl.push_back('{1'b0, 8'h00, WAIT_CONFIG_RST});
        tbl.push_back('{1'b0, 8'h04, 32'h0000_0000});
        tbl.push_back('{1'b0, 8'h08, 32'h0000_0000});
        tbl.push_back('{1'b0, 8'h0C, 32'h0000_0000});
        tbl.push_back('{1'b0, 8'h10, 32'h0000_0000});
        tbl.push_back('{1'b1, 8'h14, 32'hFFFF_FFFF});
        tbl.push_back('{1'b0, 8'h14, 32'h0000_0000});
        tbl.push_back('{1'b1, 8'h00, 32'hFFFF_FFFF});
        tbl.push_back('{1'b0, 8'h00, 32'h4000_07FF});
        tbl.push_back('{1'b1, 8'h0C, 32'h0000_0005});
        tbl.push_back('{1'b0, 8'h0C, 32'h0000_0005});
        tbl.push_back('{1'b0, 8'h10, 32'h0000_0005});
        tbl.push_back('{1'b1, 8'h0C, 32'h0000_0000});
        tbl.push_back('{1'b0, 8'h0C, 32'h0000_0005});
        tbl.push_back('{1'b1, 8'h10, 32'h0000_0001});
        tbl.push_back('{1'b0, 8'h0C, 32'h0000_0004});
        tbl.push_back('{1'b0, 8'h10, 32'h0000_0004});
        tbl.push_back('{1'b1, 8'h10, 32'h0000_0000});
        tbl.push_back('{1'b0, 8'h10, 32'h0000_0004});
        tbl.push_back('{1'b1, 8'h10, 32'h0000_0004});
        tbl.push_back('{1'b0, 8'h0C, 32'h0000_0000});
        repeat (8) @(posedge sys_clk);
        rst <= 1'b0;
        foreach (tbl[i]) begin
            if (tbl[i].wr) wr(tbl[i].a, tbl[i].d);
            else rdchk(tbl[i].a, tbl[i].d);
        end
        $display("register table done");
        wr(OFS_ENABLE_SET, 32'h0000_0004);
        illegal_pulse();
        check("irq", 1, irq);
        rdchk(OFS_RAW_STATUS, 32'h0000_0004);
        wr(OFS_RAW_STATUS, 32'h0000_0000);
        rdchk(OFS_EN_STATUS, 32'h0000_0004);
        wr(OFS_EN_STATUS, 32'h0000_0004);
        check("irq", 0, irq);
        rdchk(OFS_RAW_STATUS, 32'h0000_0000);
        wr(OFS_ENABLE_CLEAR, 32'h0000_0004);
        illegal_pulse();
        check("irq", 0, irq);
        rdchk(OFS_RAW_STATUS, 32'h0000_0004);
        rdchk(OFS_EN_STATUS, 32'h0000_0000);
        wr(OFS_RAW_STATUS, 32'h0000_0004);
        rdchk(OFS_RAW_STATUS, 32'h0000_0000);
        $display("illegal access done");
        // Limit of one unit is 16 cycles; pulse lands the cycle after
        wr(OFS_WAIT_CONFIG, 32'h4000_0001);
        access(8'd30, WAIT_UNIT, WAIT_UNIT + 1, 1);
        rdchk(OFS_RAW_STATUS, 32'h0000_0001);
        rdchk(OFS_EN_STATUS, 32'h0000_0000);
        access(8'd30, WAIT_UNIT, WAIT_UNIT + 1, 1);
        wr(OFS_RAW_STATUS, 32'h0000_0001);
        rdchk(OFS_RAW_STATUS, 32'h0000_0000);
        wr(OFS_ENABLE_SET, 32'h0000_0001);
        access(8'd30, WAIT_UNIT, WAIT_UNIT + 1, 1);
        check("irq", 1, irq);
        wr(OFS_EN_STATUS, 32'h0000_0000);
        rdchk(OFS_EN_STATUS, 32'h0000_0001);
        wr(OFS_EN_STATUS, 32'h0000_0001);
        check("irq", 0, irq);
        rdchk(OFS_RAW_STATUS, 32'h0000_0000);
        $display("timeout done");
        access(8'd3, 3, -1, 1);
        wr(OFS_WAIT_CONFIG, 32'h0000_0301);
        activeHigh <= 1'b0;
        access(8'd3, 3, -1, 4);
        $display("polarity and gap done");
        illegal_pulse();
        wr(OFS_ENABLE_SET, 32'h0000_0004);
        illegal_pulse();
        check("irq", 1, irq);
        @(posedge sys_clk);
        rst <= 1'b1;
        repeat (2) @(posedge sys_clk);
        rst <= 1'b0;
        #1;
        check("irq after reset", 0, irq);
        check("allowed after reset", 1, accessAllowed);
        check("timeout after reset", 0, waitTimeout);
        check("rdata after reset", 0, regRdData);
        rdchk(OFS_WAIT_CONFIG, WAIT_CONFIG_RST);
        rdchk(OFS_ENABLE_SET, 32'h0000_0000);
        $display("mid-run reset done");
        tally_and_finish();
    end

    // Whole sequence takes well under 2000 cycles
    initial begin
        repeat (20000) @(posedge sys_clk);
        miscompares++;
        tally_and_finish();
    end
endmodule : test_async_wait_timeout_irq_regs
